// ---- core/crm_axil_slave.v ----
// AXI4-Lite slave front end: handshakes, write strobe and read capture
`timescale 1ns/1ps
`default_nettype none

module crm_axil_slave #(
  parameter AW = 8                            // Address width
) (
  input  wire          mclk_in,              // System clock
  input  wire          rst_n_in,             // Sync reset, active low
  input  wire          ce_in,                // Clock enable
  input  wire [AW-1:0] s_axi_awaddr_in,      // Write address
  input  wire          s_axi_awvalid_in,     // Write address valid
  output wire          s_axi_awready_out,    // Write address ready
  input  wire [31:0]   s_axi_wdata_in,       // Write data
  input  wire [3:0]    s_axi_wstrb_in,       // Write byte strobes
  input  wire          s_axi_wvalid_in,      // Write data valid
  output wire          s_axi_wready_out,     // Write data ready
  output wire [1:0]    s_axi_bresp_out,      // Write response
  output wire          s_axi_bvalid_out,     // Write response valid
  input  wire          s_axi_bready_in,      // Write response ready
  input  wire [AW-1:0] s_axi_araddr_in,      // Read address
  input  wire          s_axi_arvalid_in,     // Read address valid
  output wire          s_axi_arready_out,    // Read address ready
  output wire [31:0]   s_axi_rdata_out,      // Read data
  output wire [1:0]    s_axi_rresp_out,      // Read response
  output wire          s_axi_rvalid_out,     // Read data valid
  input  wire          s_axi_rready_in,      // Read data ready
  output wire          wr_en_out,            // One-cycle register write
  output wire [AW-1:0] wr_addr_out,          // Write byte address
  output wire [31:0]   wr_data_out,          // Write data
  output wire [3:0]    wr_strb_out,          // Write strobes
  input  wire          wr_err_in,            // Write address unmapped
  output wire [AW-1:0] rd_addr_out,          // Read byte address
  input  wire [31:0]   rd_data_in,           // Read data for rd_addr
  input  wire          rd_err_in             // Read address unmapped
);

  reg          aw_hold_r;
  reg          w_hold_r;
  reg [AW-1:0] awaddr_r;
  reg [31:0]   wdata_r;
  reg [3:0]    wstrb_r;
  reg          bvalid_r;
  reg [1:0]    bresp_r;
  reg          rvalid_r;
  reg [1:0]    rresp_r;
  reg [31:0]   rdata_r;

  // Channel readies and write fire
  assign s_axi_awready_out = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready_out  = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready_out = ~rvalid_r;
  assign wr_en_out   = ce_in & aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_addr_out = awaddr_r;
  assign wr_data_out = wdata_r;
  assign wr_strb_out = wstrb_r;
  assign rd_addr_out = s_axi_araddr_in;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out  = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out  = rresp_r;
  assign s_axi_rdata_out  = rdata_r;

  // Write side: hold address and data, answer once both are in
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= {AW{1'b0}};
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata_in;
        wstrb_r  <= s_axi_wstrb_in;
      end
      if (wr_en_out) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_err_in ? 2'h2 : 2'h0;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read side: data captured at the address handshake
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rvalid_r <= 1'b0;
      rresp_r  <= 2'h0;
      rdata_r  <= 32'h0000_0000;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_err_in ? 2'h2 : 2'h0;
        rdata_r  <= rd_err_in ? 32'h0000_0000 : rd_data_in;
      end else if (rvalid_r && s_axi_rready_in) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule // crm_axil_slave

`default_nettype wire

// ---- core/crm_dbg_code.v ----
// Per-core debug status code generator, registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "crm_seq_regs.vh"

module crm_dbg_code #(
  parameter NCORE = 4                        // Number of cores
) (
  input  wire                        mclk_in,   // System clock
  input  wire                        rst_n_in,  // Sync reset, active low
  input  wire                        ce_in,     // Clock enable
  input  wire [`CRM_MODE_W-1:0]      mode_in,   // Sequencer state
  input  wire [NCORE-1:0]            active_in, // Cores running in run
  input  wire [NCORE-1:0]            cyc_sel_in,// Core chosen for cyclic
  output reg  [NCORE*`CRM_DBG_W-1:0] code_out   // Flat status codes
);

  // Code of one core for the given state
  function [`CRM_DBG_W-1:0] core_code;
    input [`CRM_MODE_W-1:0] mode;
    input                   act;
    input                   sel;
    begin
      case (mode)
        `CRM_MODE_RUN:       core_code = act ? `CRM_DBG_RUN
                                             : `CRM_DBG_INACTIVE;
        `CRM_MODE_DSTOP:     core_code = `CRM_DBG_DEEP_STOP;
        `CRM_MODE_DSTOP_CYC: core_code = `CRM_DBG_DEEP_STOP;
        `CRM_MODE_CRUN:      core_code = sel ? `CRM_DBG_CYC_RUN
                                             : `CRM_DBG_CYC_DIS;
        `CRM_MODE_CSTOP:     core_code = sel ? `CRM_DBG_CYC_STOP
                                             : `CRM_DBG_CYC_DIS;
        default:             core_code = `CRM_DBG_INACTIVE;
      endcase
    end
  endfunction

  integer i;

  // One code per core, refreshed every enabled cycle
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      code_out <= {NCORE{`CRM_DBG_INACTIVE}};
    end else if (ce_in) begin
      for (i = 0; i < NCORE; i = i + 1) begin
        code_out[i*`CRM_DBG_W +: `CRM_DBG_W] <=
          core_code(mode_in, active_in[i], cyc_sel_in[i]);
      end
    end
  end

endmodule // crm_dbg_code

`default_nettype wire

// ---- core/crm_seq_top.v ----
// Cyclic run mode sequencer: mode control, core wake and flash block
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crm_seq_regs.vh"

module crm_seq_top #(
  parameter NCORE        = 4,                 // Number of cores
  parameter WAKE_W       = 8,                 // Wakeup source count
  parameter CYC_SECONDARY = 0,                // 1: secondary core variant
  parameter [NCORE-1:0] INIT_STOPPED = 4'h0   // Cores stopped at reset
) (
  input  wire                        mclk_in,           // 250 MHz clock
  input  wire                        rst_n_in,          // Sync reset
  input  wire                        ce_in,             // Clock enable
  input  wire [7:0]                  s_axi_awaddr_in,   // Write address
  input  wire                        s_axi_awvalid_in,  // Write addr valid
  output wire                        s_axi_awready_out, // Write addr ready
  input  wire [31:0]                 s_axi_wdata_in,    // Write data
  input  wire [3:0]                  s_axi_wstrb_in,    // Write strobes
  input  wire                        s_axi_wvalid_in,   // Write data valid
  output wire                        s_axi_wready_out,  // Write data ready
  output wire [1:0]                  s_axi_bresp_out,   // Write response
  output wire                        s_axi_bvalid_out,  // Response valid
  input  wire                        s_axi_bready_in,   // Response ready
  input  wire [7:0]                  s_axi_araddr_in,   // Read address
  input  wire                        s_axi_arvalid_in,  // Read addr valid
  output wire                        s_axi_arready_out, // Read addr ready
  output wire [31:0]                 s_axi_rdata_out,   // Read data
  output wire [1:0]                  s_axi_rresp_out,   // Read response
  output wire                        s_axi_rvalid_out,  // Read data valid
  input  wire                        s_axi_rready_in,   // Read data ready
  input  wire [WAKE_W-1:0]           wake_src_in,       // Wakeup requests
  input  wire [NCORE-1:0]            core_activate_in,  // Start a stopped core
  input  wire [NCORE-1:0]            flash_req_in,      // Core flash requests
  output wire [NCORE-1:0]            flash_grant_out,   // Flash access allowed
  input  wire [NCORE-1:0]            dbg_halt_req_in,   // Debug halt requests
  output reg  [NCORE-1:0]            core_halt_out,     // Halt to cores
  output reg  [NCORE-1:0]            core_run_out,      // Core clock enable
  output reg  [NCORE-1:0]            core_reset_out,    // Core reset pulse
  output reg  [31:0]                 boot_addr_out,     // Fetch start address
  output reg                         flash_block_out,   // Flash blocked
  output wire [`CRM_MODE_W-1:0]      mode_out,          // Sequencer state
  output wire [NCORE*`CRM_DBG_W-1:0] dbg_status_out     // Per-core codes
);

  // Bus-side wires
  wire        wr_en;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [7:0]  rd_addr;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;

  // State
  reg [`CRM_MODE_W-1:0] mode_r;
  reg [`CRM_MODE_W-1:0] mode_nxt;
  reg                   key_armed_r;
  reg [`CRM_PSC_W-1:0]  psc_r;
  reg [WAKE_W-1:0]      wake_en_r;
  reg [NCORE-1:0]       active_r;
  reg [NCORE-1:0]       active_nxt;
  reg [NCORE-1:0]       rst_pulse_nxt;
  reg [NCORE-1:0]       run_nxt;
  reg [31:0]            boot_nxt;

  // Core chosen for cyclic run, fixed by the product variant
  wire [NCORE-1:0] cyc_sel;
  assign cyc_sel = (CYC_SECONDARY != 0) ? {{(NCORE-1){1'b0}}, 1'b1} << 1
                                        : {{(NCORE-1){1'b0}}, 1'b1};

  // Debug code index of an address, from the debug base
  function [7:0] dbg_index;
    input [7:0] addr;
    begin
      dbg_index = (addr - `CRM_OFS_DBG_BASE) >> 2;
    end
  endfunction

  // True for a full-word write to the given offset
  function full_wr;
    input [7:0] addr;
    input [3:0] strb;
    input [7:0] ofs;
    begin
      full_wr = (addr == ofs) && (strb == 4'hF);
    end
  endfunction

  wire key_wr = wr_en && full_wr(wr_addr, wr_strb, `CRM_OFS_KEY);
  wire psc_wr = wr_en && full_wr(wr_addr, wr_strb, `CRM_OFS_PSC);
  // mode write only when key armed
  wire psc_ok = psc_wr && key_armed_r;
  wire [`CRM_PSC_W-1:0] psc_req = psc_ok ? wr_data[`CRM_PSC_W-1:0]
                                         : `CRM_PSC_NONE;
  wire wake = |(wake_src_in & wake_en_r);

  // Register bus front end
  crm_axil_slave #(
    .AW (8)
  ) u_bus (
    .mclk_in           (mclk_in),
    .rst_n_in          (rst_n_in),
    .ce_in             (ce_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .wr_en_out         (wr_en),
    .wr_addr_out       (wr_addr),
    .wr_data_out       (wr_data),
    .wr_strb_out       (wr_strb),
    .wr_err_in         (wr_err),
    .rd_addr_out       (rd_addr),
    .rd_data_in        (rd_data),
    .rd_err_in         (rd_err)
  );

  // Per-core debug status codes
  crm_dbg_code #(
    .NCORE (NCORE)
  ) u_dbg (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .mode_in    (mode_r),
    .active_in  (active_r),
    .cyc_sel_in (cyc_sel),
    .code_out   (dbg_status_out)
  );

  // Write address decode: key, mode control and wake enable are writable
  always @* begin
    wr_err = !((wr_addr == `CRM_OFS_KEY) || (wr_addr == `CRM_OFS_PSC) ||
               (wr_addr == `CRM_OFS_WAKE_EN));
  end

  // Read mux
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (rd_addr)
      `CRM_OFS_KEY:     rd_data = 32'h0000_0000;
      `CRM_OFS_PSC:     rd_data[`CRM_PSC_W-1:0] = psc_r;
      `CRM_OFS_WAKE_EN: rd_data[WAKE_W-1:0] = wake_en_r;
      `CRM_OFS_STATUS: begin
        rd_data[`CRM_ST_MODE_LSB +: `CRM_MODE_W] = mode_r;
        rd_data[`CRM_ST_FLASH_BIT] = flash_block_out;
        rd_data[`CRM_ST_KEY_BIT]   = key_armed_r;
        rd_data[`CRM_ST_ACTIVE_LSB +: NCORE] = active_r;
      end
      default: begin
        if ((rd_addr >= `CRM_OFS_DBG_BASE) && (rd_addr[1:0] == 2'h0) &&
            (dbg_index(rd_addr) < NCORE)) begin
          rd_data[`CRM_DBG_W-1:0] =
            dbg_status_out[dbg_index(rd_addr)*`CRM_DBG_W +: `CRM_DBG_W];
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // Next state, core enables, reset pulses and fetch address
  always @* begin
    mode_nxt      = mode_r;
    active_nxt    = active_r | core_activate_in;
    rst_pulse_nxt = {NCORE{1'b0}};
    boot_nxt      = boot_addr_out;
    case (mode_r)
      `CRM_MODE_RUN: begin
        if (psc_req == `CRM_PSC_CYC_ENTRY) begin
          mode_nxt = `CRM_MODE_DSTOP_CYC;
        end else if (psc_req == `CRM_PSC_DEEP_STOP) begin
          mode_nxt = `CRM_MODE_DSTOP;
        end
      end
      `CRM_MODE_DSTOP: begin
        if (wake) begin
          mode_nxt      = `CRM_MODE_RUN;
          rst_pulse_nxt = {NCORE{1'b1}};
          active_nxt    = ~INIT_STOPPED;
          boot_nxt      = `CRM_RESET_VECTOR;
        end
      end
      `CRM_MODE_DSTOP_CYC: begin
        if (wake) begin
          mode_nxt      = `CRM_MODE_CRUN;
          rst_pulse_nxt = cyc_sel;
          boot_nxt      = `CRM_RRAM_BASE;
        end
      end
      `CRM_MODE_CRUN: begin
        if (psc_req == `CRM_PSC_CYC_STOP) begin
          mode_nxt = `CRM_MODE_CSTOP;
        end else if (psc_req == `CRM_PSC_DEEP_STOP) begin
          mode_nxt = `CRM_MODE_DSTOP;
        end
      end
      `CRM_MODE_CSTOP: begin
        if (wake) begin
          mode_nxt = `CRM_MODE_CRUN;
        end
      end
      default: mode_nxt = `CRM_MODE_RUN;
    endcase
  end

  // Core run enables for the next state
  always @* begin
    case (mode_nxt)
      `CRM_MODE_RUN:  run_nxt = active_nxt;
      `CRM_MODE_CRUN: run_nxt = cyc_sel;
      default:        run_nxt = {NCORE{1'b0}};
    endcase
  end

  // Sequencer registers
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode_r          <= `CRM_MODE_RUN;
      active_r        <= ~INIT_STOPPED;
      core_run_out    <= ~INIT_STOPPED;
      core_reset_out  <= {NCORE{1'b0}};
      boot_addr_out   <= `CRM_RESET_VECTOR;
      flash_block_out <= 1'b0;
      core_halt_out   <= {NCORE{1'b0}};
    end else if (ce_in) begin
      mode_r          <= mode_nxt;
      active_r        <= active_nxt;
      core_run_out    <= run_nxt;
      core_reset_out  <= rst_pulse_nxt;
      boot_addr_out   <= boot_nxt;
      flash_block_out <= (mode_nxt == `CRM_MODE_CRUN);
      core_halt_out   <= dbg_halt_req_in & run_nxt;
    end
  end

  // Key arming and software registers
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      key_armed_r <= 1'b0;
      psc_r       <= `CRM_RST_PSC;
      wake_en_r   <= `CRM_RST_WAKE_EN;
    end else if (ce_in) begin
      if (wr_en) begin
        key_armed_r <= key_wr && (wr_data == `CRM_KEY_VALUE);
      end
      if (psc_ok) begin
        psc_r <= wr_data[`CRM_PSC_W-1:0];
      end
      if (wr_en && (wr_addr == `CRM_OFS_WAKE_EN)) begin
        if (wr_strb[0]) begin
          wake_en_r <= wr_data[WAKE_W-1:0];
        end
      end
    end
  end

  assign flash_grant_out = flash_req_in & ~{NCORE{flash_block_out}};
  assign mode_out        = mode_r;

endmodule // crm_seq_top

`default_nettype wire

// ---- dv/crm_far_side.sv ----
// Far-side model: interval timer wakeup and flash-fetching cores
`timescale 1ns/1ps
`default_nettype none
module crm_far_side (
  input  wire logic       mclk_in,       // Clock
  input  wire logic       go_in,         // Start the interval timer
  input  wire logic       slow_in,       // Long interval when high
  input  wire logic [3:0] run_in,        // Core enables
  output var  logic [7:0] wake_out,      // Wakeup requests
  output wire logic [3:0] flash_req_out  // Flash requests
);
  logic [4:0] cnt_r = 5'h00;
  always @(posedge mclk_in) begin
    wake_out <= 8'h00;
    if (go_in) begin
      cnt_r <= slow_in ? 5'h14 : 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      wake_out <= (cnt_r == 5'h01) ? 8'h01 : 8'h02; // Bit 1 never enabled
    end
  end
  // Every running core keeps fetching from flash
  assign flash_req_out = run_in;
endmodule // crm_far_side
`default_nettype wire

// ---- dv/crm_seq_asserts.sv ----
// Assertion checker for the cyclic run mode sequencer ports
`timescale 1ns/1ps
`default_nettype none
module crm_seq_asserts #(
  parameter             NCORE         = 4,
  parameter             CYC_SECONDARY = 0,
  parameter [NCORE-1:0] INIT_STOPPED  = 4'h0
) (
  input wire logic                mclk_in,         // Clock
  input wire logic                rst_n_in,        // Sync reset
  input wire logic [2:0]          mode_out,        // Sequencer state
  input wire logic                flash_block_out, // Flash blocked
  input wire logic [NCORE-1:0]    flash_req_in,    // Flash requests
  input wire logic [NCORE-1:0]    flash_grant_out, // Flash grants
  input wire logic [NCORE-1:0]    dbg_halt_req_in, // Halt requests
  input wire logic [NCORE-1:0]    core_halt_out,   // Core halts
  input wire logic [NCORE-1:0]    core_run_out,    // Core enables
  input wire logic [NCORE-1:0]    core_reset_out,  // Core resets
  input wire logic [31:0]         boot_addr_out,   // Fetch address
  input wire logic [NCORE*16-1:0] dbg_status_out   // Debug codes
);
  // Chosen core and expected codes for four cores
  localparam [3:0]  SEL = CYC_SECONDARY ? 4'h2 : 4'h1;
  localparam [63:0] CYC = CYC_SECONDARY ? 64'h1000_1000_0400_1000
                                        : 64'h1000_1000_1000_0400;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Entry into cyclic run and stays in a mode
  sequence s_cyc_entry;
    $past(rst_n_in) && $past(mode_out) == 3'h2 && mode_out == 3'h3;
  endsequence
  sequence s_cyc_stay;
    (mode_out == 3'h3) [*2];
  endsequence
  sequence s_dstop_stay;
    (mode_out == 3'h1 || mode_out == 3'h2) [*2];
  endsequence
  a_flash_block: assert property (
    flash_block_out == (mode_out == 3'h3)) else $error("flash block wrong");
  a_flash_grant: assert property (
    flash_grant_out == (flash_req_in & ~{NCORE{flash_block_out}}))
    else $error("flash grant wrong");
  a_halt_follow: assert property (
    $past(rst_n_in) |-> core_halt_out == ($past(dbg_halt_req_in)
    & core_run_out)) else $error("halt not passed");
  a_cyc_via_stop: assert property (
    $past(rst_n_in) && mode_out == 3'h3 && $past(mode_out) != 3'h3 |->
    $past(mode_out) == 3'h2 || $past(mode_out) == 3'h4)
    else $error("cyclic run entered from wrong mode");
  a_cyc_wake_one: assert property (
    s_cyc_entry |-> core_run_out == SEL && core_reset_out == SEL
    && boot_addr_out == 32'hFE80_0000) else $error("cyclic wake wrong");
  a_cyc_codes: assert property (
    s_cyc_stay |-> dbg_status_out == CYC) else $error("cyclic codes wrong");
  a_dstop_codes: assert property (
    s_dstop_stay |-> dbg_status_out == {4{16'h0200}})
    else $error("deep stop codes wrong");
  a_leave_cyc: assert property (
    $past(rst_n_in) && $past(mode_out) == 3'h3 && mode_out != 3'h3 |->
    mode_out == 3'h1 || mode_out == 3'h4) else $error("bad cyclic exit");
  a_dstop_exit: assert property (
    $past(rst_n_in) && $past(mode_out) == 3'h1 && mode_out == 3'h0 |->
    core_reset_out == {NCORE{1'h1}} && core_run_out == ~INIT_STOPPED)
    else $error("deep stop release wrong");
endmodule // crm_seq_asserts
bind crm_seq_top crm_seq_asserts #(
  .NCORE(NCORE), .CYC_SECONDARY(CYC_SECONDARY), .INIT_STOPPED(INIT_STOPPED)
) u_crm_seq_asserts (
  .mclk_in, .rst_n_in, .mode_out, .flash_block_out, .flash_req_in,
  .flash_grant_out, .dbg_halt_req_in, .core_halt_out, .core_run_out,
  .core_reset_out, .boot_addr_out, .dbg_status_out
);
`default_nettype wire

// ---- dv/cyclic_run_mode_sequencer_bench.sv ----
// Self-checking bench of the cyclic run mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "crm_seq_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module cyclic_run_mode_sequencer_bench;
  logic        mclk_in = 0, rst_n_in = 0, go = 0, slow = 0;
  logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic        s_axi_arvalid_in = 0, s_axi_rready_in = 0, flash_block_out;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out;
  logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0, wake_src_in;
  logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, boot_addr_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [3:0]  dbg_halt_req_in = 0, flash_req_in, flash_grant_out, act = 0;
  logic [3:0]  core_halt_out, core_run_out, core_reset_out;
  logic [2:0]  mode_out;
  logic [63:0] dbg_status_out;
  int          mismatches = 0, cmp_count = 0;
  crm_seq_top #(.INIT_STOPPED(4'h8)) i_crm_seq_top (
    .mclk_in, .rst_n_in, .ce_in(1'h1), .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .wake_src_in, .core_activate_in(act), .flash_req_in, .flash_grant_out,
    .dbg_halt_req_in, .core_halt_out, .core_run_out, .core_reset_out,
    .boot_addr_out, .flash_block_out, .mode_out, .dbg_status_out
  );
  crm_far_side i_crm_far_side (
    .mclk_in, .go_in(go), .slow_in(slow), .run_in(core_run_out),
    .wake_out(wake_src_in), .flash_req_out(flash_req_in)
  );
  // System clock
  always #2 mclk_in = ~mclk_in;
  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic timeout(input int n);
    if (n >= 60) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // Bus write
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    int n;
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      if (s_axi_bvalid_out === 1'h1) break;
    end
    s_axi_bready_in <= 1'h0;
    timeout(n);
    `CHK(s_axi_bresp_out, er)
  endtask
  // Bus read
  task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    int n;
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      if (s_axi_rvalid_out === 1'h1) break;
    end
    s_axi_rready_in <= 1'h0;
    timeout(n);
    `CHK(s_axi_rdata_out, ed)
    `CHK(s_axi_rresp_out, er)
  endtask
  // Keyed mode-control write
  task automatic mode_wr(input [31:0] c);
    wr(`CRM_OFS_KEY, `CRM_KEY_VALUE, 2'h0);
    wr(`CRM_OFS_PSC, c, 2'h0);
  endtask
  task automatic wait_mode(input [2:0] m);
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk_in);
      #1;
      if (mode_out === m) break;
    end
    timeout(n);
  endtask
  // Start the far-side interval timer
  task automatic wake(input logic s);
    @(posedge mclk_in);
    go <= 1'h1;
    slow <= s;
    @(posedge mclk_in);
    go <= 1'h0;
  endtask
  // Reset view and unmapped offsets
  task automatic t_reset();
    rd(`CRM_OFS_STATUS, 32'h0000_0700, 2'h0);
    act <= 4'h8;
    rd(`CRM_OFS_DBG_BASE, 32'h0000_0001, 2'h0);
    act <= 4'h0;
    rd(`CRM_OFS_STATUS, 32'h0000_0F00, 2'h0);
    rd(8'h40, 32'h0000_0000, 2'h2);
    wr(8'h40, 32'h0000_0000, 2'h2);
  endtask
  // Mode writes without a fresh key are ignored
  task automatic t_unarmed();
    wr(`CRM_OFS_PSC, 32'h0000_0002, 2'h0);
    wr(`CRM_OFS_KEY, `CRM_KEY_VALUE, 2'h0);
    wr(`CRM_OFS_WAKE_EN, 32'h0000_0001, 2'h0);
    wr(`CRM_OFS_PSC, 32'h0000_0001, 2'h0);
    rd(`CRM_OFS_PSC, 32'h0000_0000, 2'h0);
    `CHK(mode_out, 3'h0)
  endtask
  // Entry through deep stop into cyclic run
  task automatic t_entry();
    mode_wr(32'h0000_0002);
    wait_mode(3'h2);
    `CHK(core_run_out, 4'h0)
    rd(`CRM_OFS_DBG_BASE, 32'h0000_0200, 2'h0);
    wake(1'h1);
    wait_mode(3'h3);
    `CHK(core_run_out, 4'h1)
    `CHK(core_reset_out, 4'h1)
    `CHK(boot_addr_out, `CRM_RRAM_BASE)
    `CHK(flash_grant_out, 4'h0)
    @(posedge mclk_in);
    dbg_halt_req_in <= 4'h3;
    @(posedge mclk_in);
    #1;
    `CHK(core_halt_out, 4'h1)
    @(posedge mclk_in);
    dbg_halt_req_in <= 4'h0;
    rd(`CRM_OFS_DBG_BASE, 32'h0000_0400, 2'h0);
    rd(`CRM_OFS_DBG_BASE + 8'h04, 32'h0000_1000, 2'h0);
  endtask
  // Cyclic stop and prompt return
  task automatic t_cstop();
    mode_wr(32'h0000_0003);
    wait_mode(3'h4);
    `CHK(flash_block_out, 1'h0)
    rd(`CRM_OFS_DBG_BASE, 32'h0000_0800, 2'h0);
    wake(1'h0);
    wait_mode(3'h3);
    `CHK(core_run_out, 4'h1)
  endtask
  // Refused code, deep stop, release
  task automatic t_dstop();
    mode_wr(32'h0000_0002);
    rd(`CRM_OFS_PSC, 32'h0000_0002, 2'h0);
    `CHK(mode_out, 3'h3)
    mode_wr(32'h0000_0001);
    wait_mode(3'h1);
    rd(`CRM_OFS_DBG_BASE + 8'h0C, 32'h0000_0200, 2'h0);
    wake(1'h1);
    wait_mode(3'h0);
    `CHK(core_run_out, 4'h7)
    `CHK(core_reset_out, 4'hF)
    `CHK(boot_addr_out, `CRM_RESET_VECTOR)
    `CHK(flash_grant_out, 4'h7)
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    t_reset();
    t_unarmed();
    t_entry();
    t_cstop();
    t_dstop();
    end_of_test();
  end
endmodule // cyclic_run_mode_sequencer_bench
`default_nettype wire

// ---- pkg/crm_seq_regs.vh ----
// Register map, codes and reset values of the cyclic run sequencer
`ifndef CRM_SEQ_REGS_VH
`define CRM_SEQ_REGS_VH

// Byte offsets on the register bus
`define CRM_OFS_KEY        8'h00
`define CRM_OFS_PSC        8'h04
`define CRM_OFS_WAKE_EN    8'h08
`define CRM_OFS_STATUS     8'h0C
`define CRM_OFS_DBG_BASE   8'h10

// Protection key value that arms one mode-control write
`define CRM_KEY_VALUE      32'hA5A5_A501

// Mode-control request codes (low bits of the mode-control word)
`define CRM_PSC_W          2
`define CRM_PSC_NONE       2'h0
`define CRM_PSC_DEEP_STOP  2'h1
`define CRM_PSC_CYC_ENTRY  2'h2
`define CRM_PSC_CYC_STOP   2'h3

// Sequencer states
`define CRM_MODE_W         3
`define CRM_MODE_RUN       3'h0
`define CRM_MODE_DSTOP     3'h1
`define CRM_MODE_DSTOP_CYC 3'h2
`define CRM_MODE_CRUN      3'h3
`define CRM_MODE_CSTOP     3'h4

// Debug status codes per core
`define CRM_DBG_W          16
`define CRM_DBG_RUN        16'h0001
`define CRM_DBG_INACTIVE   16'h0010
`define CRM_DBG_DEEP_STOP  16'h0200
`define CRM_DBG_CYC_RUN    16'h0400
`define CRM_DBG_CYC_STOP   16'h0800
`define CRM_DBG_CYC_DIS    16'h1000

// Fetch start addresses
`define CRM_RRAM_BASE      32'hFE80_0000
`define CRM_RESET_VECTOR   32'h0000_0000

// Status register fields
`define CRM_ST_MODE_LSB    0
`define CRM_ST_FLASH_BIT   3
`define CRM_ST_KEY_BIT     4
`define CRM_ST_ACTIVE_LSB  8

// Reset values
`define CRM_RST_WAKE_EN    8'h00
`define CRM_RST_PSC        2'h0

`endif
